// File: rtl/scs_pkg.sv
package scs_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CLK_SRC   = 8'h8f;
  localparam logic [7:0] IDX_IOSC_CTL  = 8'ha1;
  localparam logic [7:0] IDX_XOSC_CTL  = 8'hb1;
  localparam logic [7:0] IDX_IRQ_STAT  = 8'hb2;
  localparam logic [7:0] IDX_IRQ_MASK  = 8'hb3;
  // clock source field
  localparam logic [1:0] SRC_INT       = 2'h0;
  localparam logic [1:0] SRC_EXT       = 2'h1;
  localparam logic [1:0] SRC_MUL       = 2'h2;
  localparam logic [1:0] SRC_RSV       = 2'h3;
  // internal oscillator control fields
  localparam int         IOSC_EN_LSB   = 6;
  localparam int         IOSC_SUSP_BIT = 5;
  localparam int         IOSC_RDY_BIT  = 4;
  localparam logic [1:0] IOSC_EN_OFF   = 2'h0;
  localparam logic [1:0] IOSC_EN_ON    = 2'h3;
  localparam logic [1:0] IOSC_EN_RST   = 2'h3;
  localparam logic [2:0] DIV_CODE_RST  = 3'h0;
  localparam logic [1:0] CLK_SRC_RST   = 2'h0;
  // external oscillator control fields
  localparam int         XOSC_EN_BIT   = 0;
  localparam int         XOSC_XTAL_BIT = 1;
  localparam int         XOSC_VLD_BIT  = 7;
  localparam int         XTAL_SETTLE   = 1024;
  // interrupt status bits
  localparam int         EV_WAKE       = 0;
  localparam int         EV_XTAL_VLD   = 1;
  localparam int         EV_SWITCHED   = 2;
  localparam int         EV_N          = 3;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } scs_wb_req_t;

  // divisor for a divider code: 000 gives 128, 111 gives 1
  function automatic logic [7:0] scs_div_f(input logic [2:0] code);
    scs_div_f = 8'h80 >> code;
  endfunction : scs_div_f
endpackage : scs_pkg

// File: rtl/scs_div.sv
`timescale 1ns/1ps
module scs_div
  import scs_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  // divider
  input  wire logic       tick_i,
  input  wire logic [2:0] code_i,
  output logic            tick_o
);
  logic [6:0] cnt_q;
  logic [7:0] div;

  assign div = scs_div_f(code_i);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_q  <= 7'h00;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (tick_i) begin
        if ({1'b0, cnt_q} >= div - 8'h01) begin
          cnt_q  <= 7'h00;
          tick_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 7'h01;
        end
      end
    end
  end

  property p_div_one;
    @(posedge clk_sys_i) disable iff (rst_i)
      (code_i == 3'h7 && tick_i && cnt_q == 7'h00) |=> tick_o;
  endproperty
  a_div_one: assert property (p_div_one) else $error("divide by one lost a tick");
endmodule : scs_div

// File: rtl/scs_switch.sv
`timescale 1ns/1ps
module scs_switch
  import scs_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  // sources, indexed by source code
  input  wire logic [2:0] tick_i,
  input  wire logic [2:0] alive_i,
  input  wire logic [1:0] req_i,
  // selected clock
  output logic [1:0]      cur_o,
  output logic            en_o,
  output logic            switched_o
);
  logic go;

  // change right after a whole period of the old source, or at once if the old source is not alive
  assign go = (req_i != cur_o) && (req_i != SRC_RSV) &&
              (tick_i[cur_o] || !alive_i[cur_o]);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cur_o      <= SRC_INT;
      switched_o <= 1'b0;
    end else begin
      switched_o <= go;
      if (go) begin
        cur_o <= req_i;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      en_o <= 1'b0;
    end else begin
      en_o <= (cur_o != SRC_RSV) && tick_i[cur_o];
    end
  end

  property p_no_rsv;
    @(posedge clk_sys_i) disable iff (rst_i) req_i == SRC_RSV |=> $stable(cur_o);
  endproperty
  a_no_rsv: assert property (p_no_rsv) else $error("reserved source taken");

  property p_clean;
    @(posedge clk_sys_i) disable iff (rst_i)
      (cur_o != $past(cur_o)) |-> $past(tick_i[cur_o] || !alive_i[cur_o]);
  endproperty
  a_clean: assert property (p_clean) else $error("switch cut a clock period");
endmodule : scs_switch

// File: rtl/scs_top.sv
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// - source field 00 internal divided, 01 external, 10 multiplier, 11 reserved
// - external oscillator keeps clocking timers whatever source is selected
// - internal oscillator usable as source right after its enable write
// - crystal valid flag goes to 1 once the crystal has settled
// - upper six bits of source select read zero, writes ignored
// - after reset run from internal oscillator divided by 128
// - divider code 000 divides by 128, each step halves, 111 by one
// - writing suspend halts internal oscillator and clocks fed from it
// - port 0..3 match or enabled comparator 0 low wakes from suspend
// - wake resumes clocks whether or not an interrupt is raised
// - enable field 00 off, 11 on but stopped in suspend, others reserved
// - frequency ready flag reads 1 while oscillator runs at set rate
// - internal control bit 3 reads 0 and must be written 0
module scs_top
  import scs_pkg::*;
#(
  parameter int XTAL_TICKS = XTAL_SETTLE
)(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // register bus
  input  wire scs_wb_req_t wb_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // oscillator sources, one-cycle ticks
  input  wire logic        ext_tick_i,
  input  wire logic        mul_tick_i,
  input  wire logic        mul_alive_i,
  // wake sources
  input  wire logic [3:0]  port_match_i,
  input  wire logic        cmp0_en_i,
  input  wire logic        cmp0_out_i,
  // clock enables and status
  output logic             system_clock_en_o,
  output logic             timer_clk_en_o,
  output logic             core_halt_o,
  output logic             iosc_run_o,
  output logic             irq_o
);
  // ****************************************
  // bus decode
  // ****************************************
  logic              req;
  logic              wr;
  logic              rd;
  logic [7:0]        idx;
  logic [7:0]        wdat;
  logic [1:0]        src_q;
  logic [1:0]        ien_q;
  logic              susp_q;
  logic [2:0]        dcode_q;
  logic              xen_q;
  logic              xmode_q;
  logic              xvld_q;
  logic              xvld_prev_q;
  logic [12:0]       xcnt_q;
  logic [EV_N-1:0]   stat_q;
  logic [EV_N-1:0]   mask_q;
  logic [EV_N-1:0]   ev;
  logic              wake;
  logic              div_tick;
  logic              switched;
  logic [1:0]        cur_src;
  logic [7:0]        rdat;

  assign req  = wb_i.cyc && wb_i.stb && !wb_ack_o;
  assign wr   = req && wb_i.we && wb_i.sel[0];
  assign rd   = req && !wb_i.we;
  assign idx  = wb_i.adr[9:2];
  assign wdat = wb_i.dat[7:0];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // ****************************************
  // clock source select
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      src_q <= CLK_SRC_RST;
    end else if (wr && hit(idx, IDX_CLK_SRC)) begin
      src_q <= wdat[1:0];
    end
  end

  // ****************************************
  // internal oscillator control
  // ****************************************
  assign wake = (|port_match_i) || (cmp0_en_i && !cmp0_out_i);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ien_q   <= IOSC_EN_RST;
      dcode_q <= DIV_CODE_RST;
    end else if (wr && hit(idx, IDX_IOSC_CTL)) begin
      ien_q   <= wdat[IOSC_EN_LSB +: 2];
      dcode_q <= wdat[2:0];
    end
  end

  // a suspend write in the same cycle as a wake still suspends
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      susp_q <= 1'b0;
    end else if (wr && hit(idx, IDX_IOSC_CTL) && wdat[IOSC_SUSP_BIT]) begin
      susp_q <= 1'b1;
    end else if (wake) begin
      susp_q <= 1'b0;
    end
  end

  // the system clock stands in for the oscillator itself, so it is
  // ready the cycle after the enable write
  assign iosc_run_o  = (ien_q == IOSC_EN_ON) && !susp_q;
  assign core_halt_o = susp_q && (cur_src == SRC_INT);

  scs_div u_div (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .tick_i    (iosc_run_o),
    .code_i    (dcode_q),
    .tick_o    (div_tick)
  );

  // ****************************************
  // external oscillator and crystal valid
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      xen_q   <= 1'b0;
      xmode_q <= 1'b0;
    end else if (wr && hit(idx, IDX_XOSC_CTL)) begin
      xen_q   <= wdat[XOSC_EN_BIT];
      xmode_q <= wdat[XOSC_XTAL_BIT];
    end
  end

  // crystal counts settle ticks; rc and c modes are valid at once
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !xen_q) begin
      xcnt_q <= 13'h0000;
      xvld_q <= 1'b0;
    end else if (!xmode_q || xcnt_q >= 13'(XTAL_TICKS)) begin
      xvld_q <= 1'b1;
    end else if (ext_tick_i) begin
      xcnt_q <= xcnt_q + 13'h0001;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      timer_clk_en_o <= 1'b0;
    end else begin
      timer_clk_en_o <= ext_tick_i && xen_q;
    end
  end

  // ****************************************
  // glitch free source switch
  // ****************************************
  scs_switch u_sw (
    .clk_sys_i  (clk_sys_i),
    .rst_i      (rst_i),
    .tick_i     ({mul_tick_i, ext_tick_i && xen_q, div_tick}),
    .alive_i    ({mul_alive_i, xen_q, iosc_run_o}),
    .req_i      (src_q),
    .cur_o      (cur_src),
    .en_o       (system_clock_en_o),
    .switched_o (switched)
  );

  // ****************************************
  // interrupts
  // ****************************************
  // previous valid level, for the rising edge event
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      xvld_prev_q <= 1'b0;
    end else begin
      xvld_prev_q <= xvld_q;
    end
  end

  assign ev = {switched, xvld_q && !xvld_prev_q, susp_q && wake};

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      stat_q <= '0;
    end else if (wr && hit(idx, IDX_IRQ_STAT)) begin
      stat_q <= (stat_q & ~wdat[EV_N-1:0]) | ev;
    end else begin
      stat_q <= stat_q | ev;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mask_q <= '0;
    end else if (wr && hit(idx, IDX_IRQ_MASK)) begin
      mask_q <= wdat[EV_N-1:0];
    end
  end

  assign irq_o = |(stat_q & mask_q);

  // ****************************************
  // read back
  // ****************************************
  always_comb begin
    rdat = 8'h00;
    case (idx)
      IDX_CLK_SRC:  rdat = {6'h00, src_q};
      IDX_IOSC_CTL: rdat = {ien_q, susp_q, iosc_run_o, 1'b0, dcode_q};
      IDX_XOSC_CTL: rdat = {xvld_q, 5'h00, xmode_q, xen_q};
      IDX_IRQ_STAT: rdat = {5'h00, stat_q};
      IDX_IRQ_MASK: rdat = {5'h00, mask_q};
      default:      rdat = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd) begin
      wb_dat_o <= {24'h000000, rdat};
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_rst_src;
    @(posedge clk_sys_i) $fell(rst_i) |-> src_q == SRC_INT && dcode_q == 3'h0 && cur_src == SRC_INT;
  endproperty
  a_rst_src: assert property (p_rst_src) else $error("bad state after reset");

  property p_rsv_zero;
    @(posedge clk_sys_i) disable iff (rst_i)
      rd && hit(idx, IDX_CLK_SRC) |=> wb_ack_o && wb_dat_o[7:2] == 6'h00;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("select upper bits not zero");

  property p_bit3;
    @(posedge clk_sys_i) disable iff (rst_i)
      rd && hit(idx, IDX_IOSC_CTL) |=> wb_dat_o[3] == 1'b0 && wb_dat_o[4] == $past(iosc_run_o);
  endproperty
  a_bit3: assert property (p_bit3) else $error("control readback wrong");

  property p_susp;
    @(posedge clk_sys_i) disable iff (rst_i)
      wr && hit(idx, IDX_IOSC_CTL) && wdat[IOSC_SUSP_BIT] |=> !iosc_run_o ##1 !div_tick;
  endproperty
  a_susp: assert property (p_susp) else $error("suspend did not halt");

  property p_halt;
    @(posedge clk_sys_i) disable iff (rst_i)
      core_halt_o && $past(core_halt_o, 2) |-> !system_clock_en_o;
  endproperty
  a_halt: assert property (p_halt) else $error("system clock runs while halted");

  property p_wake;
    @(posedge clk_sys_i) disable iff (rst_i)
      susp_q && wake && !wr ##1 ien_q == IOSC_EN_ON |-> iosc_run_o;
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not resume");

  property p_en_off;
    @(posedge clk_sys_i) disable iff (rst_i) ien_q != IOSC_EN_ON |-> !iosc_run_o;
  endproperty
  a_en_off: assert property (p_en_off) else $error("oscillator runs while off");

  property p_timer;
    @(posedge clk_sys_i) disable iff (rst_i) ext_tick_i && xen_q |=> timer_clk_en_o;
  endproperty
  a_timer: assert property (p_timer) else $error("timer clock lost");

  property p_xvld;
    @(posedge clk_sys_i) disable iff (rst_i)
      xen_q && !xmode_q ##1 xen_q |-> xvld_q;
  endproperty
  a_xvld: assert property (p_xvld) else $error("valid flag not set");

  property p_int_now;
    @(posedge clk_sys_i) disable iff (rst_i)
      wr && hit(idx, IDX_IOSC_CTL) && wdat[7:6] == IOSC_EN_ON && !wdat[IOSC_SUSP_BIT]
      |=> iosc_run_o;
  endproperty
  a_int_now: assert property (p_int_now) else $error("oscillator not ready at once");
endmodule : scs_top

// File: test/scs_top_tb.sv
`timescale 1ns/1ps
module scs_top_tb
  import scs_pkg::*;
();
  logic        clk_sys_i    = 1'b0;
  logic        rst_i        = 1'b1;
  scs_wb_req_t wb_i         = '0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        ext_tick_i   = 1'b0;
  logic        mul_tick_i   = 1'b0;
  logic        mul_alive_i  = 1'b0;
  logic [3:0]  port_match_i = 4'h0;
  logic        cmp0_en_i    = 1'b0;
  logic        cmp0_out_i   = 1'b1;
  logic        system_clock_en_o;
  logic        timer_clk_en_o;
  logic        core_halt_o;
  logic        iosc_run_o;
  logic        irq_o;
  logic [2:0]  ext_cnt      = 3'h0;
  logic [1:0]  mul_cnt      = 2'h0;
  logic [7:0]  n;
  int          n_errors     = 0;
  int          comparisons  = 0;

  scs_top #(.XTAL_TICKS(8)) dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ext_tick_i(ext_tick_i), .mul_tick_i(mul_tick_i),
    .mul_alive_i(mul_alive_i), .port_match_i(port_match_i), .cmp0_en_i(cmp0_en_i),
    .cmp0_out_i(cmp0_out_i), .system_clock_en_o(system_clock_en_o), .timer_clk_en_o(timer_clk_en_o),
    .core_halt_o(core_halt_o), .iosc_run_o(iosc_run_o), .irq_o(irq_o)
  );

  always #50 clk_sys_i = ~clk_sys_i;

  // oscillator ticks: external every 5 cycles, multiplier every 3
  always @(posedge clk_sys_i) begin
    ext_cnt    <= (ext_cnt == 3'h4) ? 3'h0 : ext_cnt + 3'h1;
    ext_tick_i <= (ext_cnt == 3'h4);
    mul_cnt    <= (mul_cnt == 2'h2) ? 2'h0 : mul_cnt + 2'h1;
    mul_tick_i <= (mul_cnt == 2'h2);
  end

  // ****************************************
  // checking and bus tasks
  // ****************************************
  task print_verdict;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  task stall;
    n_errors++;
    $display("BAD t=%0t wait timed out", $time);
    print_verdict();
  endtask : stall

  task chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8

  task chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk1

  task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd);
    int k;
    k = 0;
    @(posedge clk_sys_i);
    wb_i <= {1'b1, 1'b1, we, {2'h0, idx, 2'h0}, 4'h1, {24'h0, wd}};
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (k >= 20) stall();
    rd = wb_dat_o[7:0];
    wb_i <= '0;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, idx, d, x);
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] x;
    bus(1'b0, idx, 8'h00, x);
    chk8(x, exp);
  endtask : rdc

  // cycles between two pulses of system or timer clock enable
  task automatic period(input logic tmr);
    int k;
    k = 0;
    repeat (2) begin
      do begin
        @(negedge clk_sys_i);
        k++;
      end while ((tmr ? timer_clk_en_o : system_clock_en_o) !== 1'b1 && k < 400);
    end
    n = 8'h00;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while ((tmr ? timer_clk_en_o : system_clock_en_o) !== 1'b1 && n < 8'd200);
    if (k >= 400 || n >= 8'd200) stall();
  endtask : period

  task do_reset;
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
  endtask : do_reset

  // ****************************************
  // scenarios
  // ****************************************
  task automatic wake(input int s);
    logic b0;
    wr(IDX_IOSC_CTL, 8'he7);
    @(negedge clk_sys_i);
    repeat (4) begin
      @(negedge clk_sys_i);
      chk1(core_halt_o, 1'b1);
      chk1(system_clock_en_o, 1'b0);
    end
    chk1(iosc_run_o, 1'b0);
    @(posedge clk_sys_i);
    if (s < 4) port_match_i[s] <= 1'b1;
    else cmp0_en_i <= 1'b1;
    if (s == 4) begin
      repeat (3) @(negedge clk_sys_i);
      chk1(core_halt_o, 1'b1);
      @(posedge clk_sys_i);
      cmp0_out_i <= 1'b0;
    end
    @(posedge clk_sys_i);
    port_match_i <= 4'h0;
    cmp0_en_i    <= 1'b0;
    cmp0_out_i   <= 1'b1;
    repeat (3) @(negedge clk_sys_i);
    chk1(core_halt_o, 1'b0);
    chk1(iosc_run_o, 1'b1);
    rdc(IDX_IOSC_CTL, 8'hd7);
    rdc(IDX_IRQ_STAT, 8'h01);
    wr(IDX_IRQ_MASK, 8'h00);
    @(negedge clk_sys_i);
    b0 = irq_o;
    wr(IDX_IRQ_MASK, 8'h07);
    @(negedge clk_sys_i);
    chk1(b0, 1'b0);
    chk1(irq_o, 1'b1);
    wr(IDX_IRQ_STAT, 8'h07);
    @(negedge clk_sys_i);
    chk1(irq_o, 1'b0);
  endtask : wake

  task ext_and_mul;
    repeat (12) @(negedge clk_sys_i) chk1(timer_clk_en_o, 1'b0);
    wr(IDX_XOSC_CTL, 8'h03);
    rdc(IDX_XOSC_CTL, 8'h03);
    period(1'b1);
    chk8(n, 8'd5);
    repeat (60) @(negedge clk_sys_i);
    rdc(IDX_XOSC_CTL, 8'h83);
    rdc(IDX_IRQ_STAT, 8'h02);
    wr(IDX_IRQ_STAT, 8'h07);
    wr(IDX_CLK_SRC, 8'h01);
    rdc(IDX_CLK_SRC, 8'h01);
    period(1'b0);
    chk8(n, 8'd5);
    rdc(IDX_IRQ_STAT, 8'h04);
    for (int e = 0; e < 3; e++) begin
      wr(IDX_IOSC_CTL, {e[1:0], 6'h07});
      @(negedge clk_sys_i);
      chk1(iosc_run_o, 1'b0);
    end
    wr(IDX_IOSC_CTL, 8'hc7);
    wr(IDX_CLK_SRC, 8'h00);
    period(1'b0);
    chk8(n, 8'd1);
    @(posedge clk_sys_i);
    mul_alive_i <= 1'b1;
    wr(IDX_CLK_SRC, 8'h02);
    period(1'b0);
    chk8(n, 8'd3);
    wr(IDX_CLK_SRC, 8'h03);
    period(1'b0);
    chk8(n, 8'd3);
    // rc mode: valid without settle wait
    wr(IDX_XOSC_CTL, 8'h00);
    rdc(IDX_XOSC_CTL, 8'h00);
    wr(IDX_XOSC_CTL, 8'h01);
    rdc(IDX_XOSC_CTL, 8'h81);
  endtask : ext_and_mul

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    do_reset();
    chk1(iosc_run_o, 1'b1);
    rdc(IDX_CLK_SRC, 8'h00);
    rdc(IDX_IOSC_CTL, 8'hd0);
    period(1'b0);
    chk8(n, 8'd128);
    wr(8'h10, 8'hff);
    rdc(8'h10, 8'h00);
    wr(IDX_CLK_SRC, 8'hfc);
    rdc(IDX_CLK_SRC, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(IDX_IOSC_CTL, {5'h18, c[2:0]});
      period(1'b0);
      chk8(n, 8'h80 >> c);
    end
    wr(IDX_IOSC_CTL, 8'hcf);
    rdc(IDX_IOSC_CTL, 8'hd7);
    for (int s = 0; s < 5; s++) wake(s);
    ext_and_mul();
    do_reset();
    rdc(IDX_CLK_SRC, 8'h00);
    rdc(IDX_IOSC_CTL, 8'hd0);
    period(1'b0);
    chk8(n, 8'd128);
    print_verdict();
  end
endmodule : scs_top_tb
